// file: hdl/dtec_timer.sv
// dual 8-bit timer/event counter with cascade, registers and interrupt
`timescale 1ns/1ps
//
// Contract
// - each counter steps by one on every tick of its count clock
// - counters are eight bits, software may read but never write them
// - counter goes to zero on reset, enable clear, clear-mode match
// - in cascade, lower enable clear zeroes both counters
// - in cascade, both counters form one 16-bit count, upper is high
// - outside pwm, counter equal to compare raises the match interrupt
// - in pwm, overflow drives output active, match drives it inactive
// - compare holds any byte value and is readable and writable
// - in cascade, 16-bit compare match raises only lower interrupt
// - three-bit select picks pin edges, five divisors, or other match
// - clock select reads zero in upper five bits, clears on reset
// - single channels allow all modes, cascade allows all but pwm
// - enable set starts counting, enable clear zeroes and holds
// - set and reset bits force the output flip-flop, both is ignored
module dtec_timer (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [1:0] i_event_pin,
   input wire logic i_other_match,
   output logic [1:0] o_timer_out,
   output logic o_irq
);
   logic [1:0] pin_s1_ff;
   logic [1:0] pin_s2_ff;
   logic [7:0] div_ff;
   dtec_pkg::dtec_div_type div_tick;
   logic [7:0] cnt_ff [2];
   logic [7:0] cmp_ff [2];
   logic [2:0] csel_ff [2];
   dtec_pkg::dtec_mode_type mode_ff [2];
   logic [1:0] tick;
   logic [1:0] out_ff;
   logic [1:0] stat_ff;
   logic [1:0] irq_en_ff;
   logic [7:0] rdata_ff;
   logic [1:0] out_pin_ff;
   logic irq_ff;
   logic casc;
   logic [1:0] pwm_eff;
   logic [1:0] run;
   logic [1:0] match_evt;
   logic [1:0] ovf_evt;
   logic match16;
   logic [1:0] mode_wr;
   dtec_pkg::dtec_mode_type wmode;
   logic [7:0] nxt_rdata;

   assign casc = mode_ff[1].casc;
   assign wmode = dtec_pkg::dtec_mode_type'(i_wdata);
   assign mode_wr[0] = i_wr && (i_addr == dtec_pkg::OFS_MODE0);
   assign mode_wr[1] = i_wr && (i_addr == dtec_pkg::OFS_MODE1);

   // event pins cross in through two flops before the edge detectors
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_s1_ff <= 2'h0;
         pin_s2_ff <= 2'h0;
      end else if (i_ce) begin
         pin_s1_ff <= i_event_pin;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // shared free-running prescaler for the divided count clocks
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_ff <= 8'h00;
      end else if (i_ce) begin
         div_ff <= div_ff + 8'h01;
      end
   end

   assign div_tick.d2 = &(div_ff | ~dtec_pkg::DIV2_MASK);
   assign div_tick.d4 = &(div_ff | ~dtec_pkg::DIV4_MASK);
   assign div_tick.d64 = &(div_ff | ~dtec_pkg::DIV64_MASK);
   assign div_tick.d256 = &(div_ff | ~dtec_pkg::DIV256_MASK);

   // one count clock selector per channel
   for (genvar g = 0; g < 2; g++) begin : g_sel
      dtec_clk_sel u_sel (
         .i_clk(i_clk),
         .i_arst_n(i_arst_n),
         .i_ce(i_ce),
         .i_sel(csel_ff[g]),
         .i_pin(pin_s2_ff[g]),
         .i_div(div_tick),
         .i_other_match(i_other_match),
         .o_tick(tick[g])
      );
   end

   // cascade forces clear-and-start: no pwm on the 16-bit pair
   assign pwm_eff[0] = mode_ff[0].pwm & ~casc;
   assign pwm_eff[1] = mode_ff[1].pwm & ~casc;
   // in cascade the upper half follows the lower enable
   assign run[0] = mode_ff[0].en;
   assign run[1] = casc ? mode_ff[0].en : mode_ff[1].en;
   assign match16 = {cnt_ff[1], cnt_ff[0]} == {cmp_ff[1], cmp_ff[0]};

   // match events, taken on the count tick that sees equality
   always_comb begin
      match_evt = 2'b00;
      ovf_evt = 2'b00;
      if (casc) begin
         match_evt[0] = run[0] && tick[0] && match16;
      end else begin
         for (int c = 0; c < 2; c++) begin
            match_evt[c] = run[c] && tick[c]
               && (cnt_ff[c] == cmp_ff[c]);
            ovf_evt[c] = run[c] && tick[c] && pwm_eff[c]
               && (cnt_ff[c] == dtec_pkg::CNT_MAX);
         end
      end
   end

   // lower counter: free run in pwm, clear on match otherwise
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_ff[0] <= dtec_pkg::RST_CNT;
      end else if (i_ce) begin
         if (!run[0]) begin
            cnt_ff[0] <= dtec_pkg::RST_CNT;
         end else if (match_evt[0] && !pwm_eff[0]) begin
            cnt_ff[0] <= dtec_pkg::RST_CNT;
         end else if (tick[0]) begin
            cnt_ff[0] <= cnt_ff[0] + 8'h01;
         end
      end
   end

   // upper counter: own tick, or carry from the lower byte in cascade
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_ff[1] <= dtec_pkg::RST_CNT;
      end else if (i_ce) begin
         if (!run[1]) begin
            cnt_ff[1] <= dtec_pkg::RST_CNT;
         end else if (casc) begin
            if (match_evt[0]) begin
               cnt_ff[1] <= dtec_pkg::RST_CNT;
            end else if (tick[0] && cnt_ff[0] == dtec_pkg::CNT_MAX) begin
               cnt_ff[1] <= cnt_ff[1] + 8'h01;
            end
         end else if (match_evt[1] && !pwm_eff[1]) begin
            cnt_ff[1] <= dtec_pkg::RST_CNT;
         end else if (tick[1]) begin
            cnt_ff[1] <= cnt_ff[1] + 8'h01;
         end
      end
   end

   // compare and clock select; counters have no write path
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmp_ff[0] <= dtec_pkg::RST_CMP;
         cmp_ff[1] <= dtec_pkg::RST_CMP;
         csel_ff[0] <= dtec_pkg::RST_CSEL;
         csel_ff[1] <= dtec_pkg::RST_CSEL;
      end else if (i_ce && i_wr) begin
         unique case (i_addr)
            dtec_pkg::OFS_CMP0: cmp_ff[0] <= i_wdata;
            dtec_pkg::OFS_CMP1: cmp_ff[1] <= i_wdata;
            dtec_pkg::OFS_CSEL0: csel_ff[0] <= i_wdata[2:0];
            dtec_pkg::OFS_CSEL1: csel_ff[1] <= i_wdata[2:0];
            default: ; // count, status and unmapped writes are dropped
         endcase
      end
   end

   // mode control; set/reset fields act once and are not stored
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_ff[0] <= dtec_pkg::dtec_mode_type'(dtec_pkg::RST_MODE);
         mode_ff[1] <= dtec_pkg::dtec_mode_type'(dtec_pkg::RST_MODE);
      end else if (i_ce) begin
         for (int c = 0; c < 2; c++) begin
            if (mode_wr[c]) begin
               mode_ff[c] <= wmode;
               mode_ff[c].rsv <= 1'b0;
               mode_ff[c].lvs <= 1'b0;
               mode_ff[c].lvr <= 1'b0;
               mode_ff[c].casc <= (c == 1) ? wmode.casc : 1'b0;
            end
         end
      end
   end

   // timer output flip-flops: forced by software, moved by events
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_ff <= 2'h0;
      end else if (i_ce) begin
         for (int c = 0; c < 2; c++) begin
            if (mode_wr[c] && wmode.lvs && !wmode.lvr) begin
               out_ff[c] <= 1'b1;
            end else if (mode_wr[c] && wmode.lvr && !wmode.lvs) begin
               out_ff[c] <= 1'b0;
            end else if (pwm_eff[c] && ovf_evt[c]) begin
               out_ff[c] <= 1'b1;
            end else if (pwm_eff[c] && match_evt[c]) begin
               out_ff[c] <= 1'b0;
            end else if (!pwm_eff[c] && mode_ff[c].inv
                         && match_evt[casc ? 0 : c]) begin
               out_ff[c] <= ~out_ff[c];
            end
         end
      end
   end

   // pin drive: pwm level is inverted when active low is chosen
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_pin_ff <= 2'h0;
      end else if (i_ce) begin
         for (int c = 0; c < 2; c++) begin
            out_pin_ff[c] <= mode_ff[c].toe
               & (out_ff[c] ^ (pwm_eff[c] & mode_ff[c].inv));
         end
      end
   end
   assign o_timer_out = out_pin_ff;

   // sticky status: a new match wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stat_ff <= dtec_pkg::RST_IRQ;
         irq_en_ff <= dtec_pkg::RST_IRQ;
      end else if (i_ce) begin
         if (i_wr && i_addr == dtec_pkg::OFS_IRQ_CLR) begin
            stat_ff <= (stat_ff & ~i_wdata[1:0]) | match_evt;
         end else begin
            stat_ff <= stat_ff | match_evt;
         end
         if (i_wr && i_addr == dtec_pkg::OFS_IRQ_EN) begin
            irq_en_ff <= i_wdata[1:0];
         end
      end
   end

   // level interrupt, one flop after the status that causes it
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_ff <= 1'b0;
      end else if (i_ce) begin
         irq_ff <= |(stat_ff & irq_en_ff);
      end
   end
   assign o_irq = irq_ff;

   // read mux; unmapped and write-only offsets read zero
   always_comb begin
      unique case (i_addr)
         dtec_pkg::OFS_CNT0: nxt_rdata = cnt_ff[0];
         dtec_pkg::OFS_CMP0: nxt_rdata = cmp_ff[0];
         dtec_pkg::OFS_CSEL0: nxt_rdata = {5'h00, csel_ff[0]};
         dtec_pkg::OFS_MODE0: nxt_rdata = mode_ff[0];
         dtec_pkg::OFS_CNT1: nxt_rdata = cnt_ff[1];
         dtec_pkg::OFS_CMP1: nxt_rdata = cmp_ff[1];
         dtec_pkg::OFS_CSEL1: nxt_rdata = {5'h00, csel_ff[1]};
         dtec_pkg::OFS_MODE1: nxt_rdata = mode_ff[1];
         dtec_pkg::OFS_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
         dtec_pkg::OFS_IRQ_EN: nxt_rdata = {6'h00, irq_en_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   // read data stands for the one cycle after the strobe only
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_ff <= 8'h00;
      end else if (i_ce) begin
         rdata_ff <= i_rd ? nxt_rdata : 8'h00;
      end
   end
   assign o_rdata = rdata_ff;

   // checks: each guards one documented behaviour of the timer
   cnt_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && !mode_ff[0].en |=> cnt_ff[0] == 8'h00)
      else $error("lower counter not zero while disabled");

   cnt_step_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && run[0] && tick[0] && pwm_eff[0]
      |=> cnt_ff[0] == 8'($past(cnt_ff[0]) + 8'h01))
      else $error("lower counter missed a step");

   casc_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && casc && !mode_ff[0].en |=> cnt_ff[1] == 8'h00)
      else $error("upper counter not cleared by lower enable");

   casc_carry_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && casc && run[0] && tick[0] && !match16
      && cnt_ff[0] == 8'hFF
      |=> cnt_ff[1] == 8'($past(cnt_ff[1]) + 8'h01) && cnt_ff[0] == 8'h00)
      else $error("cascade carry lost");

   match_irq_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && match_evt[0] && irq_en_ff[0] |=> stat_ff[0] ##1 o_irq)
      else $error("match did not raise interrupt");

   pwm_level_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && !mode_wr[0] && ovf_evt[0] |=> out_ff[0])
      else $error("pwm overflow did not set output");

   casc_irq_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && casc && !stat_ff[1] |=> !stat_ff[1])
      else $error("upper interrupt raised in cascade");

   csel_zero_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && i_rd && i_addr == dtec_pkg::OFS_CSEL0 |=> o_rdata[7:3] == 5'h00)
      else $error("clock select upper bits not zero");

   level_set_a: assert property (
      @(posedge i_clk) disable iff (!i_arst_n)
      i_ce && mode_wr[0] && wmode.lvs && !wmode.lvr |=> out_ff[0])
      else $error("output flip-flop not set by software");

   match_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      match_evt[1] && !pwm_eff[1]);
   casc_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      casc && match_evt[0] && cnt_ff[1] != 8'h00);
   pwm_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      ovf_evt[0] ##[1:600] pwm_eff[0] && match_evt[0]);
endmodule : dtec_timer

// file: hdl/dtec_pkg.sv
// package: register map, field layouts and codes of the dual timer
package dtec_pkg;

   // register offsets on the 4-bit byte address port
   localparam logic [3:0] OFS_CNT0 = 4'h0;
   localparam logic [3:0] OFS_CMP0 = 4'h1;
   localparam logic [3:0] OFS_CSEL0 = 4'h2;
   localparam logic [3:0] OFS_MODE0 = 4'h3;
   localparam logic [3:0] OFS_CNT1 = 4'h4;
   localparam logic [3:0] OFS_CMP1 = 4'h5;
   localparam logic [3:0] OFS_CSEL1 = 4'h6;
   localparam logic [3:0] OFS_MODE1 = 4'h7;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h9;
   localparam logic [3:0] OFS_IRQ_EN = 4'hA;

   // values after reset, and the top count value
   localparam logic [7:0] RST_CNT = 8'h00;
   localparam logic [7:0] RST_CMP = 8'h00;
   localparam logic [2:0] RST_CSEL = 3'h0;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [7:0] CNT_MAX = 8'hFF;

   // prescaler taps: all ones in these low bits marks a divided tick
   localparam logic [7:0] DIV2_MASK = 8'h01;
   localparam logic [7:0] DIV4_MASK = 8'h03;
   localparam logic [7:0] DIV64_MASK = 8'h3F;
   localparam logic [7:0] DIV256_MASK = 8'hFF;

   // count source codes of the three-bit clock select field
   typedef enum logic [2:0] {
      CSEL_PIN_FALL = 3'h0,
      CSEL_PIN_RISE = 3'h1,
      CSEL_DIV1 = 3'h2,
      CSEL_DIV2 = 3'h3,
      CSEL_DIV4 = 3'h4,
      CSEL_DIV64 = 3'h5,
      CSEL_DIV256 = 3'h6,
      CSEL_OTHER = 3'h7
   } dtec_csel_type;

   // mode control layout, bit 7 down to bit 0
   typedef struct packed {
      logic en;     // count enable
      logic pwm;    // 1 = pwm free run, 0 = clear and start on match
      logic rsv;    // reads zero
      logic casc;   // cascade, upper channel only
      logic lvs;    // output flip-flop set, write only
      logic lvr;    // output flip-flop reset, write only
      logic inv;    // toggle enable, or active low in pwm
      logic toe;    // output enable
   } dtec_mode_type;

   // prescaler taps handed to each clock selector
   typedef struct packed {
      logic d256;
      logic d64;
      logic d4;
      logic d2;
   } dtec_div_type;

endpackage : dtec_pkg

// file: hdl/dtec_clk_sel.sv
// count clock selector: one count tick per selected source event
`timescale 1ns/1ps
module dtec_clk_sel (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic [2:0] i_sel,
   input wire logic i_pin,
   input wire dtec_pkg::dtec_div_type i_div,
   input wire logic i_other_match,
   output logic o_tick
);
   logic pin_prev_ff;

   // previous level of the already synchronised event pin
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_prev_ff <= 1'b0;
      end else if (i_ce) begin
         pin_prev_ff <= i_pin;
      end
   end

   // source mux; the divided clocks are single-cycle enables
   always_comb begin
      unique case (dtec_pkg::dtec_csel_type'(i_sel))
         dtec_pkg::CSEL_PIN_FALL: o_tick = pin_prev_ff & ~i_pin;
         dtec_pkg::CSEL_PIN_RISE: o_tick = ~pin_prev_ff & i_pin;
         dtec_pkg::CSEL_DIV1: o_tick = 1'b1;
         dtec_pkg::CSEL_DIV2: o_tick = i_div.d2;
         dtec_pkg::CSEL_DIV4: o_tick = i_div.d4;
         dtec_pkg::CSEL_DIV64: o_tick = i_div.d64;
         dtec_pkg::CSEL_DIV256: o_tick = i_div.d256;
         dtec_pkg::CSEL_OTHER: o_tick = i_other_match;
      endcase
   end
endmodule : dtec_clk_sel

// file: tb/dtec_pin_model.sv
// pin model: drives the event inputs and watches timer output 0
`timescale 1ns/1ps
module dtec_pin_model (
   input wire logic i_clk,
   input wire logic [1:0] i_timer_out,
   output logic [1:0] o_event_pin
);
   int high_cnt;

   // pins idle low, so no edge reaches the counter straight after reset
   initial begin
      o_event_pin = 2'h0;
      high_cnt = 0;
   end

   // each level is held four clocks so the two-flop sync sees both edges
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_event_pin[ch] <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_event_pin[ch] <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask : pulse

   // clocks with channel 0 output high, used for duty measurements
   always @(posedge i_clk) begin
      if (i_timer_out[0] === 1'b1) begin
         high_cnt <= high_cnt + 1;
      end
   end
endmodule : dtec_pin_model

// file: tb/test_dtec_timer.sv
// testbench: register-level scenarios for the dual timer
`timescale 1ns/1ps
module test_dtec_timer;
   logic clk;
   logic arst_n;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic [1:0] pin;
   logic other;
   logic ce;
   logic [1:0] tout;
   logic irq;
   int fail_count;
   int checks;
   logic [7:0] rv;
   logic [7:0] lo;
   logic [7:0] hi;
   int h0;
   int dv [2:6] = '{1, 2, 4, 64, 256};

   dtec_timer dtec_timer_i (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_event_pin(pin), .i_other_match(other),
      .o_timer_out(tout), .o_irq(irq));
   dtec_pin_model dtec_pin_model_i (.i_clk(clk), .i_timer_out(tout),
      .o_event_pin(pin));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // one-cycle bus strobes, changed just after the edge
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // count values whose phase against the prescaler is not fixed
   task automatic chk_rng(input logic [15:0] got, input logic [15:0] l,
      input logic [15:0] h);
      checks++;
      if ((got >= l && got <= h) !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h to %h", $time,
            got, l, h);
      end
   endtask : chk_rng

   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(16'(d), 16'(e));
   endtask : rc

   // bounded wait for the interrupt line
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(irq), 16'h0001);
   endtask : wait_irq

   task automatic duty(input int l, input int h);
      repeat (300) @(posedge clk);
      h0 = dtec_pin_model_i.high_cnt;
      repeat (256) @(posedge clk);
      chk_rng(16'(dtec_pin_model_i.high_cnt - h0), 16'(l), 16'(h));
   endtask : duty

   task automatic print_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // watchdog: the sequence needs well under ten thousand cycles
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      arst_n = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      other = 1'b0;
      ce = 1'b1;
      fail_count = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // reset values, read-only counter, masked select, unmapped place
      rc(dtec_pkg::OFS_CNT0, 8'h00);
      rc(dtec_pkg::OFS_CSEL1, 8'h00);
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h00);
      wr_reg(dtec_pkg::OFS_CMP1, 8'hFF);
      rc(dtec_pkg::OFS_CMP1, 8'hFF);
      wr_reg(dtec_pkg::OFS_CMP1, 8'h00);
      rc(dtec_pkg::OFS_CMP1, 8'h00);
      wr_reg(dtec_pkg::OFS_CSEL0, 8'hFF);
      rc(dtec_pkg::OFS_CSEL0, 8'h07);
      wr_reg(dtec_pkg::OFS_CNT0, 8'h55);
      rc(dtec_pkg::OFS_CNT0, 8'h00);
      rc(4'hF, 8'h00);
      // each prescaler tap gives about eight steps in eight periods
      wr_reg(dtec_pkg::OFS_CMP0, 8'hFF);
      for (int c = 2; c <= 6; c++) begin
         wr_reg(dtec_pkg::OFS_CSEL0, 8'(c));
         wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
         repeat (8 * dv[c]) @(posedge clk);
         rd_reg(dtec_pkg::OFS_CNT0, rv);
         chk_rng(16'(rv), 16'h0007, 16'h000A);
         wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
         rc(dtec_pkg::OFS_CNT0, 8'h00);
      end
      // clock enable low freezes the count: two steps, not twenty-two
      wr_reg(dtec_pkg::OFS_CSEL0, 8'h02);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
      @(posedge clk);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      rc(dtec_pkg::OFS_CNT0, 8'h02);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      // falling and rising pin edges
      for (int c = 0; c <= 1; c++) begin
         wr_reg(dtec_pkg::OFS_CSEL0, 8'(c));
         wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
         dtec_pin_model_i.pulse(0, 5);
         rc(dtec_pkg::OFS_CNT0, 8'h05);
         wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      end
      // other timer's match pulses as count source
      wr_reg(dtec_pkg::OFS_CSEL0, 8'h07);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
      repeat (3) begin
         @(posedge clk);
         other <= 1'b1;
         @(posedge clk);
         other <= 1'b0;
      end
      repeat (2) @(posedge clk);
      rc(dtec_pkg::OFS_CNT0, 8'h03);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      // square wave on clear-and-start: period six, toggling on each match every three clocks
      wr_reg(dtec_pkg::OFS_CSEL0, 8'h02);
      wr_reg(dtec_pkg::OFS_CMP0, 8'h02);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h83);
      h0 = dtec_pin_model_i.high_cnt;
      repeat (60) @(posedge clk);
      chk_rng(16'(dtec_pin_model_i.high_cnt - h0), 16'd27, 16'd33);
      rd_reg(dtec_pkg::OFS_CNT0, rv);
      chk_rng(16'(rv), 16'h0000, 16'h0002);
      // interrupt masked, then enabled, then cleared
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h01);
      chk(16'(irq), 16'h0000);
      wr_reg(dtec_pkg::OFS_IRQ_EN, 8'h01);
      wait_irq(4);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      wr_reg(dtec_pkg::OFS_IRQ_CLR, 8'h01);
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h00);
      chk(16'(irq), 16'h0000);
      // output flip-flop forced while stopped; both bits leave it alone
      wr_reg(dtec_pkg::OFS_MODE0, 8'h09);
      repeat (2) @(posedge clk);
      chk(16'(tout[0]), 16'h0001);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h05);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h0D);
      repeat (2) @(posedge clk);
      chk(16'(tout[0]), 16'h0000);
      rc(dtec_pkg::OFS_MODE0, 8'h01);
      // pwm: high from overflow through the match count
      wr_reg(dtec_pkg::OFS_CMP0, 8'h40);
      wr_reg(dtec_pkg::OFS_MODE0, 8'hC1);
      duty(64, 66);
      wr_reg(dtec_pkg::OFS_CMP0, 8'h80);
      duty(128, 130);
      wr_reg(dtec_pkg::OFS_MODE0, 8'hC3);
      duty(126, 128);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      // upper channel alone: own pin, then square wave with its interrupt
      wr_reg(dtec_pkg::OFS_CMP1, 8'hFF);
      wr_reg(dtec_pkg::OFS_CSEL1, 8'h01);
      wr_reg(dtec_pkg::OFS_MODE1, 8'h80);
      dtec_pin_model_i.pulse(1, 3);
      rc(dtec_pkg::OFS_CNT1, 8'h03);
      wr_reg(dtec_pkg::OFS_MODE1, 8'h00);
      wr_reg(dtec_pkg::OFS_CSEL1, 8'h02);
      wr_reg(dtec_pkg::OFS_CMP1, 8'h03);
      // the pwm run left a stale lower status bit: clear both first
      wr_reg(dtec_pkg::OFS_IRQ_CLR, 8'h03);
      wr_reg(dtec_pkg::OFS_MODE1, 8'h83);
      repeat (20) @(posedge clk);
      #1;
      rv[0] = tout[1];
      repeat (4) @(posedge clk);
      #1;
      chk(16'(tout[1] ^ rv[0]), 16'h0001);
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h02);
      wr_reg(dtec_pkg::OFS_MODE1, 8'h00);
      wr_reg(dtec_pkg::OFS_IRQ_CLR, 8'h03);
      // cascade event count, 300 events, read twice against tearing
      wr_reg(dtec_pkg::OFS_CMP0, 8'hFF);
      wr_reg(dtec_pkg::OFS_CMP1, 8'hFF);
      wr_reg(dtec_pkg::OFS_MODE1, 8'h10);
      wr_reg(dtec_pkg::OFS_CSEL0, 8'h01);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
      dtec_pin_model_i.pulse(0, 300);
      rd_reg(dtec_pkg::OFS_CNT0, lo);
      rd_reg(dtec_pkg::OFS_CNT1, hi);
      rd_reg(dtec_pkg::OFS_CNT0, rv);
      chk(16'(rv), 16'(lo));
      chk({hi, lo}, 16'h012C);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      rc(dtec_pkg::OFS_CNT0, 8'h00);
      rc(dtec_pkg::OFS_CNT1, 8'h00);
      // sixteen-bit match raises the lower interrupt only
      wr_reg(dtec_pkg::OFS_CMP0, 8'h02);
      wr_reg(dtec_pkg::OFS_CMP1, 8'h01);
      wr_reg(dtec_pkg::OFS_CSEL0, 8'h02);
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h00);
      chk(16'(irq), 16'h0000);
      wr_reg(dtec_pkg::OFS_IRQ_EN, 8'h03);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h80);
      wait_irq(300);
      wr_reg(dtec_pkg::OFS_MODE0, 8'h00);
      rc(dtec_pkg::OFS_IRQ_STAT, 8'h01);
      print_verdict();
   end
endmodule : test_dtec_timer
